/* File: design/dcic_consts.svh */
// Offsets, field positions, reset values and write mask of the capture unit
`ifndef DCIC_CONSTS_SVH
`define DCIC_CONSTS_SVH
`define DCIC_OFF_CONTROL 20'h40c14
`define DCIC_OFF_VALUES 20'h40c18
`define DCIC_BIT_ENABLE 0
`define DCIC_BIT_CH1_EDGE 1
`define DCIC_BIT_CH2_EDGE 2
`define DCIC_LSB_PRESCALE 16
`define DCIC_LSB_SRC1 20
`define DCIC_BIT_CH2_SRC 22
`define DCIC_BIT_PIN_TRIG 23
`define DCIC_CONTROL_RESET 32'h00000000
`define DCIC_CONTROL_WMASK 32'h00ff0007
`define DCIC_PIN_SEL_RESET 3'h0
`endif

/* File: design/dcic_pkg.sv */
// Types shared by the capture unit
package dcic_pkg;
  typedef enum logic [1:0] {
    DCIC_SRC_RSV = 2'b00,
    DCIC_SRC_LVD = 2'b01,
    DCIC_SRC_LSCK = 2'b10,
    DCIC_SRC_PIN = 2'b11
  } dcic_src_t;
  typedef struct packed {
    logic pin_trig_level_n;
    logic ch2_source_select;
    dcic_src_t ch1_source_select;
    logic [3:0] ch1_prescale;
    logic ch2_edge_select;
    logic ch1_edge_select;
    logic capture_unit_enable;
  } dcic_ctrl_t;
  typedef struct packed {
    logic ch1_capture_flag;
    logic ch2_capture_flag;
  } dcic_flags_t;
endpackage

/* File: design/dcic_capture_unit.sv */
// Two-channel input capture unit with APB register access
//
// Overview of operation
// R1: Software sets channel 1 clock, source, prescale, edge, pin, interrupts, then enable.
// R2: Software sets channel 2 clock, source, edge, pin, interrupts, then enable.
// R3: Control bit 22 picks channel 2 source: 0 own pin, 1 channel 1 source.
// R4: Channel 2 trigger goes straight to its edge detector, never prescaled.
// R5: Source field 21:20: 01 low-voltage detect, 10 low-speed clock, 00 reserved.
// R6: Prescale field 19:16 divides channel 1 input by two to that power.
// R7: Bit 23 chooses level (0) or rising-edge (1) trigger for channel 1 pin.
// R8: Bit 1 selects channel 1 capture edge: 0 rising, 1 falling.
// R9: Bit 2 selects channel 2 capture edge: 0 rising, 1 falling.
// R10: Bit 0 enables capture; clearing it keeps both capture values.
// R11: A channel 2 capture pulses the channel 2 capture flag.
// R12: Software enables per-channel and global interrupts to receive them.
// R13: Capture value bits 31:16 read the channel 2 value, read only.
// R14: Capture value bits 15:0 read the channel 1 value, read only.
// R15: A 3-bit code picks the pin pair from port 1 or port 2.
// R16: A trigger copies the shared counter into that channel's capture value.
// R17: A channel 1 capture pulses the channel 1 capture flag.
// R18: Source code 11 takes channel 1 from its pin chosen by the pair code.
// R19: Inputs pass two flip-flops before edge detection.
// R20: Control bits 31:24, 15:3 read zero and ignore writes.
`timescale 1ns/1ps
`include "dcic_consts.svh"
module dcic_capture_unit
  import dcic_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Tick enable from the timer clock divider
  input wire logic timer_tick_clock,
  // Shared counter from the timer
  input wire logic [CNT_W-1:0] shared_counter_value,
  // Capture sources
  input wire logic [7:0] port1_pins,
  input wire logic [7:0] port2_pins,
  input wire logic [2:0] pin_pair_select,
  input wire logic low_voltage_detect_out,
  input wire logic low_speed_clock,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture flag pulses toward the interrupt flag register
  output dcic_flags_t capture_flags
);

  dcic_ctrl_t ctrl;
  logic [CNT_W-1:0] ch1_capture_value;
  logic [CNT_W-1:0] ch2_capture_value;
  logic [1:0] pin_sync1;
  logic [1:0] pin_sync2;
  logic [1:0] int_sync1;
  logic [1:0] int_sync2;
  logic pin1_prev;
  logic ch1_cond;
  logic [14:0] pre_cnt;
  logic pre_out;
  logic pre_prev;
  logic ch2_prev;
  logic ch1_src;
  logic ch2_src;
  logic ch1_hit;
  logic ch2_hit;
  logic pin1_raw;
  logic pin2_raw;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] next_rdata;

  // Pin pair picks: low two bits of code pick the pair, top bit the port
  function automatic logic [1:0] pick_pair(input logic [2:0] code, input logic [7:0] p1,
                                           input logic [7:0] p2);
    logic [7:0] port;
    port = code[2] ? p2 : p1;
    pick_pair = {port[{code[1:0], 1'b1}], port[{code[1:0], 1'b0}]};
  endfunction

  // Edge selected capture: 0 rising, 1 falling
  function automatic logic edge_hit(input logic falling, input logic prev, input logic cur);
    edge_hit = falling ? (prev & ~cur) : (~prev & cur);
  endfunction

  always_comb
  begin
    {pin2_raw, pin1_raw} = pick_pair(pin_pair_select, port1_pins, port2_pins); // R15
  end

  // Two-stage synchronisers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_sync1 <= 2'h0;
      pin_sync2 <= 2'h0;
      int_sync1 <= 2'h0;
      int_sync2 <= 2'h0;
    end
    else
    begin
      pin_sync1 <= {pin2_raw, pin1_raw}; // R19
      pin_sync2 <= pin_sync1;
      int_sync1 <= {low_speed_clock, low_voltage_detect_out};
      int_sync2 <= int_sync1;
    end
  end

  // Pin conditioning: level passes through, rising-edge mode toggles per rising edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin1_prev <= 1'b0;
      ch1_cond <= 1'b0;
    end
    else
    begin
      pin1_prev <= pin_sync2[0];
      if (!ctrl.pin_trig_level_n)
        ch1_cond <= pin_sync2[0]; // R7
      else if (pin_sync2[0] && !pin1_prev)
        ch1_cond <= ~ch1_cond; // R7
    end
  end

  always_comb
  begin
    unique case (ctrl.ch1_source_select)
      DCIC_SRC_LVD: ch1_src = int_sync2[0]; // R5
      DCIC_SRC_LSCK: ch1_src = int_sync2[1]; // R5
      DCIC_SRC_PIN: ch1_src = ch1_cond; // R18
      DCIC_SRC_RSV: ch1_src = 1'b0; // R5
    endcase
    ch2_src = ctrl.ch2_source_select ? ch1_src : pin_sync2[1]; // R3 R4
  end

  // Prescaler: bit n of a counter of source rising edges divides by 2^(n+1)
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_cnt <= 15'h0000;
      pre_prev <= 1'b0;
    end
    else
    begin
      pre_prev <= ch1_src;
      if (!ctrl.capture_unit_enable)
        pre_cnt <= 15'h0000;
      else if (ch1_src && !pre_prev)
        pre_cnt <= pre_cnt + 15'h0001; // R6
    end
  end

  always_comb
  begin
    if (ctrl.ch1_prescale == 4'h0)
      pre_out = pre_prev; // R6
    else
      pre_out = pre_cnt[ctrl.ch1_prescale - 4'h1]; // R6
  end

  // Edge detection and capture, stepped on the timer tick
  logic pre_out_q;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_out_q <= 1'b0;
      ch2_prev <= 1'b0;
    end
    else if (timer_tick_clock)
    begin
      pre_out_q <= pre_out;
      ch2_prev <= ch2_src;
    end
  end

  assign ch1_hit = timer_tick_clock && ctrl.capture_unit_enable &&
                   edge_hit(ctrl.ch1_edge_select, pre_out_q, pre_out); // R8 R10
  assign ch2_hit = timer_tick_clock && ctrl.capture_unit_enable &&
                   edge_hit(ctrl.ch2_edge_select, ch2_prev, ch2_src); // R9 R4 R10

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ch1_capture_value <= '0;
      ch2_capture_value <= '0;
    end
    else
    begin
      if (ch1_hit)
        ch1_capture_value <= shared_counter_value; // R16 R10
      if (ch2_hit)
        ch2_capture_value <= shared_counter_value; // R16 R10
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      capture_flags <= '0;
    else
    begin
      capture_flags.ch1_capture_flag <= ch1_hit; // R17
      capture_flags.ch2_capture_flag <= ch2_hit; // R11
    end
  end

  // APB slave: zero wait states, unmapped reads zero with error
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl <= '0;
    else if (apb_wr && paddr == `DCIC_OFF_CONTROL)
    begin
      ctrl.capture_unit_enable <= pwdata[`DCIC_BIT_ENABLE]; // R10
      ctrl.ch1_edge_select <= pwdata[`DCIC_BIT_CH1_EDGE]; // R8
      ctrl.ch2_edge_select <= pwdata[`DCIC_BIT_CH2_EDGE]; // R9
      ctrl.ch1_prescale <= pwdata[`DCIC_LSB_PRESCALE +: 4]; // R6
      ctrl.ch1_source_select <= dcic_src_t'(pwdata[`DCIC_LSB_SRC1 +: 2]); // R5
      ctrl.ch2_source_select <= pwdata[`DCIC_BIT_CH2_SRC]; // R3
      ctrl.pin_trig_level_n <= pwdata[`DCIC_BIT_PIN_TRIG]; // R7
    end
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (paddr == `DCIC_OFF_CONTROL)
    begin
      next_rdata[`DCIC_BIT_ENABLE] = ctrl.capture_unit_enable; // R20
      next_rdata[`DCIC_BIT_CH1_EDGE] = ctrl.ch1_edge_select;
      next_rdata[`DCIC_BIT_CH2_EDGE] = ctrl.ch2_edge_select;
      next_rdata[`DCIC_LSB_PRESCALE +: 4] = ctrl.ch1_prescale;
      next_rdata[`DCIC_LSB_SRC1 +: 2] = ctrl.ch1_source_select;
      next_rdata[`DCIC_BIT_CH2_SRC] = ctrl.ch2_source_select;
      next_rdata[`DCIC_BIT_PIN_TRIG] = ctrl.pin_trig_level_n;
    end
    else if (paddr == `DCIC_OFF_VALUES)
    begin
      next_rdata[31:16] = 16'(ch2_capture_value); // R13
      next_rdata[15:0] = 16'(ch1_capture_value); // R14
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != `DCIC_OFF_CONTROL && paddr != `DCIC_OFF_VALUES;
      if (apb_rd)
        prdata <= next_rdata;
    end
  end

  // Assertions
  property p_ch1_capture;
    @(posedge clk) disable iff (reset)
    ch1_hit |=> ch1_capture_value == $past(shared_counter_value) && capture_flags[1];
  endproperty
  a_ch1_capture: assert property (p_ch1_capture) else $error("ch1 capture wrong"); // R16

  property p_ch2_capture;
    @(posedge clk) disable iff (reset)
    ch2_hit |=> ch2_capture_value == $past(shared_counter_value) && capture_flags[0];
  endproperty
  a_ch2_capture: assert property (p_ch2_capture) else $error("ch2 capture wrong"); // R16

  property p_ch2_flag;
    @(posedge clk) disable iff (reset)
    ch2_hit |=> capture_flags.ch2_capture_flag ##1 !capture_flags.ch2_capture_flag || $past(ch2_hit);
  endproperty
  a_ch2_flag: assert property (p_ch2_flag) else $error("ch2 flag wrong"); // R11

  property p_disabled_hold;
    @(posedge clk) disable iff (reset)
    !ctrl.capture_unit_enable |=> $stable(ch1_capture_value) && $stable(ch2_capture_value);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("value changed when off"); // R10

  property p_ch2_src;
    @(posedge clk) disable iff (reset)
    ctrl.ch2_source_select |-> ch2_src == ch1_src;
  endproperty
  a_ch2_src: assert property (p_ch2_src) else $error("ch2 source wrong"); // R3

  property p_values_read;
    @(posedge clk) disable iff (reset)
    apb_rd && paddr == `DCIC_OFF_VALUES |=>
      prdata == {$past(ch2_capture_value), $past(ch1_capture_value)};
  endproperty
  a_values_read: assert property (p_values_read) else $error("value read wrong"); // R13

  property p_ctrl_zero;
    @(posedge clk) disable iff (reset)
    apb_rd && paddr == `DCIC_OFF_CONTROL |=> (prdata & ~`DCIC_CONTROL_WMASK) == 32'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("reserved bits set"); // R20

  property p_flag1_cause;
    @(posedge clk) disable iff (reset)
    capture_flags.ch1_capture_flag |-> $past(ctrl.capture_unit_enable && timer_tick_clock);
  endproperty
  a_flag1_cause: assert property (p_flag1_cause) else $error("ch1 flag without cause"); // R17

  property p_flag2_cause;
    @(posedge clk) disable iff (reset)
    capture_flags.ch2_capture_flag |-> $past(ctrl.capture_unit_enable && timer_tick_clock);
  endproperty
  a_flag2_cause: assert property (p_flag2_cause) else $error("ch2 flag without cause"); // R11

  property p_rsv_src;
    @(posedge clk) disable iff (reset)
    ctrl.ch1_source_select == DCIC_SRC_RSV && $past(ctrl.ch1_source_select) == DCIC_SRC_RSV &&
      ctrl.ch1_prescale == 4'h0 && !ctrl.ch1_edge_select |-> !ch1_src && !ch1_hit;
  endproperty
  a_rsv_src: assert property (p_rsv_src) else $error("reserved source active"); // R5

  c_ch1: cover property (@(posedge clk) disable iff (reset) ch1_hit);
  c_ch2: cover property (@(posedge clk) disable iff (reset) ch2_hit && ctrl.ch2_source_select);
  c_pre: cover property (@(posedge clk) disable iff (reset) ch1_hit && ctrl.ch1_prescale != 4'h0);
  c_pin_edge: cover property (@(posedge clk) disable iff (reset) ch1_hit && ctrl.pin_trig_level_n);
  c_fall: cover property (@(posedge clk) disable iff (reset) ch2_hit && ctrl.ch2_edge_select);

endmodule // dcic_capture_unit

/* File: verification/dcic_src_model.sv */
// Far-side model: timer tick, shared counter and capture sources
`timescale 1ns/1ps
module dcic_src_model (
  // Clock
  input wire logic clk,
  // Timer side
  output logic timer_tick_clock,
  output logic [15:0] shared_counter_value,
  // Capture sources
  output logic [7:0] port1_pins,
  output logic [7:0] port2_pins,
  output logic low_voltage_detect_out,
  output logic low_speed_clock
);
  logic [17:0] lvl = 18'h00000;
  initial timer_tick_clock = 1'b0;
  initial shared_counter_value = 16'h0000;
  assign {low_speed_clock, low_voltage_detect_out, port2_pins, port1_pins} = lvl;
  // Tick every other cycle, as a divided timer clock would
  always @(posedge clk) timer_tick_clock <= ~timer_tick_clock;
  // Each source level is held long enough for sync and the next tick
  task automatic set(input int idx, input logic v);
    @(posedge clk);
    lvl[idx] <= v;
    repeat (8) @(posedge clk);
  endtask
  // Counter is held still so a capture has one known value
  task automatic count(input logic [15:0] v);
    @(posedge clk);
    shared_counter_value <= v;
  endtask
endmodule // dcic_src_model

/* File: verification/dcic_capture_unit_tb.sv */
// Self-checking bench of the two-channel capture unit
`timescale 1ns/1ps
`include "dcic_consts.svh"
module dcic_capture_unit_tb;
  import dcic_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0] pin_pair_select = 3'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dcic_flags_t capture_flags;
  logic timer_tick_clock;
  logic [15:0] shared_counter_value;
  logic [7:0] port1_pins;
  logic [7:0] port2_pins;
  logic low_voltage_detect_out;
  logic low_speed_clock;
  int n_mismatch = 0;
  int comparisons = 0;
  int n1 = 0;
  int n2 = 0;
  int b1 = 0;
  int b2 = 0;
  always #2 clk = ~clk;
  dcic_capture_unit DUT (
    .clk(clk), .reset(reset), .timer_tick_clock(timer_tick_clock),
    .shared_counter_value(shared_counter_value), .port1_pins(port1_pins),
    .port2_pins(port2_pins), .pin_pair_select(pin_pair_select),
    .low_voltage_detect_out(low_voltage_detect_out), .low_speed_clock(low_speed_clock),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_flags(capture_flags)
  );
  dcic_src_model P (
    .clk(clk), .timer_tick_clock(timer_tick_clock),
    .shared_counter_value(shared_counter_value), .port1_pins(port1_pins),
    .port2_pins(port2_pins), .low_voltage_detect_out(low_voltage_detect_out),
    .low_speed_clock(low_speed_clock)
  );
  // Count capture pulses
  always @(posedge clk)
  begin
    if (capture_flags.ch1_capture_flag === 1'b1)
      n1++;
    if (capture_flags.ch2_capture_flag === 1'b1)
      n2++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [19:0] a, input logic [31:0] exp, input logic ee,
                     input string msg);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, msg);
    chk({31'h0, err}, {31'h0, ee}, msg);
  endtask
  // Configure with enable clear, then set enable last
  task automatic cfg(input logic [31:0] v);
    wr(`DCIC_OFF_CONTROL, v & 32'hfffffffe);
    wr(`DCIC_OFF_CONTROL, v);
  endtask
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      P.set(idx, 1'b1);
      P.set(idx, 1'b0);
    end
  endtask
  task automatic flags(input int e1, input int e2);
    chk(n1 - b1, e1, "ch1 flags");
    chk(n2 - b2, e2, "ch2 flags");
    b1 = n1;
    b2 = n2;
  endtask
  task automatic t_regs;
    rdc(`DCIC_OFF_CONTROL, 32'h00000000, 1'b0, "ctl reset");
    rdc(`DCIC_OFF_VALUES, 32'h00000000, 1'b0, "val reset");
    wr(`DCIC_OFF_CONTROL, 32'hffffffff);
    rdc(`DCIC_OFF_CONTROL, 32'h00ff0007, 1'b0, "ctl mask");
    wr(`DCIC_OFF_CONTROL, 32'h00000000);
    wr(`DCIC_OFF_VALUES, 32'h12345678);
    rdc(`DCIC_OFF_VALUES, 32'h00000000, 1'b0, "val ro");
    rdc(20'h40c1c, 32'h00000000, 1'b1, "unmapped");
  endtask
  task automatic t_pins;
    for (int c = 0; c < 8; c++)
    begin
      int p;
      p = (c / 4) * 8 + (c % 4) * 2;
      pin_pair_select <= c[2:0];
      cfg(32'h00300001);
      P.count(16'h1000 + 16'(c));
      pulse(p, 1);
      flags(1, 0);
      P.count(16'h2000 + 16'(c));
      pulse(p + 1, 1);
      flags(0, 1);
      rdc(`DCIC_OFF_VALUES, {16'h2000 + 16'(c), 16'h1000 + 16'(c)}, 1'b0, "pair");
    end
  endtask
  task automatic t_edges;
    pin_pair_select <= 3'h0;
    cfg(32'h00300007);
    P.count(16'h0abc);
    P.set(0, 1'b1);
    P.set(1, 1'b1);
    flags(0, 0);
    P.set(0, 1'b0);
    flags(1, 0);
    P.count(16'h0def);
    P.set(1, 1'b0);
    flags(0, 1);
    rdc(`DCIC_OFF_VALUES, 32'h0def0abc, 1'b0, "fall vals");
  endtask
  task automatic t_src;
    cfg(32'h00500001);
    P.count(16'h0011);
    pulse(16, 1);
    flags(1, 1);
    rdc(`DCIC_OFF_VALUES, 32'h00110011, 1'b0, "shared src");
    cfg(32'h00600001);
    pulse(17, 1);
    flags(1, 1);
    cfg(32'h00400001);
    pulse(16, 1);
    pulse(17, 1);
    flags(0, 0);
  endtask
  task automatic t_pre;
    cfg(32'h00520001);
    pulse(16, 8);
    flags(2, 8);
  endtask
  task automatic t_trig;
    cfg(32'h00b00001);
    pulse(0, 4);
    flags(2, 0);
    cfg(32'h00300001);
    pulse(0, 2);
    flags(2, 0);
  endtask
  task automatic t_enable;
    P.count(16'h5a5a);
    pulse(0, 1);
    pulse(1, 1);
    flags(1, 1);
    wr(`DCIC_OFF_CONTROL, 32'h00300000);
    P.count(16'h1111);
    pulse(0, 1);
    pulse(1, 1);
    flags(0, 0);
    rdc(`DCIC_OFF_VALUES, 32'h5a5a5a5a, 1'b0, "kept");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_pins;
    t_edges;
    t_src;
    t_pre;
    t_trig;
    t_enable;
    end_sim;
  end
  // Watchdog well beyond the expected run of under a thousand cycles
  initial
  begin
    #(80000);
    n_mismatch++;
    end_sim;
  end
endmodule // dcic_capture_unit_tb
